// >>> cprsc_static_ctrl.sv
// Static configuration registers of the radio link core, reached over AXI4-Lite
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Line rate code 0,1,2 give 614.4, 1228.8, 2457.6 Mbps; 3 varies by variant.
// - Serdes rate code 0..3 give 614.4 to 3072 Mbps; width 2 or 3 bits.
// - Rising edge of standby force sends the startup machine to Standby.
// - Transmit fast management pointer is used as given; sender keeps it 0 to 63.
// - Five HDLC enables each allow 240, 480, 960, 1920 or 2400 kHz.
// - Automatic count set means transmitted frame numbers advance on their own.
// - Hyperframe init value feeds transmitted words or loads the hyperframe counter.
// - Frame init value feeds transmitted words or loads the frame counter.
// - With its enable set, transmit sync clears the hyperframe number.
// - With its enable set, transmit sync clears the frame number.
// - Test select makes the internal timer run faster.
// - Role select 0 means RE, 1 means REC.
module cprsc_static_ctrl #(
   parameter int RATE_W = 2,
   parameter bit VARIANT_3G = 1'b1,
   parameter int TIMER_CYCLES = cprsc_pkg::TIMER_CYC
) (
   // Clock, reset, enable
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   // AXI4-Lite write
   input wire logic [cprsc_pkg::AXI_AW-1:0] I_AXI_AWADDR,
   input wire logic I_AXI_AWVALID,
   output logic O_AXI_AWREADY,
   input wire logic [cprsc_pkg::AXI_DW-1:0] I_AXI_WDATA,
   input wire logic [3:0] I_AXI_WSTRB,
   input wire logic I_AXI_WVALID,
   output logic O_AXI_WREADY,
   output logic [1:0] O_AXI_BRESP,
   output logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [cprsc_pkg::AXI_AW-1:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   output logic O_AXI_ARREADY,
   output logic [cprsc_pkg::AXI_DW-1:0] O_AXI_RDATA,
   output logic [1:0] O_AXI_RRESP,
   output logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   // Framing events
   input wire logic I_TX_SYNC,
   input wire logic I_HYPER_TICK,
   // Configuration to the core
   output logic [RATE_W-1:0] O_LINE_RATE_SEL,
   output logic [RATE_W-1:0] O_SERDES_RATE_SEL,
   output logic [15:0] O_LINE_RATE_X100K,
   output logic [15:0] O_SERDES_RATE_X100K,
   output logic O_STANDBY_FORCE,
   output logic [cprsc_pkg::PTR_W-1:0] O_TX_POINTER,
   output logic [cprsc_pkg::HDLC_N-1:0] O_HDLC_EN,
   output logic [11:0] O_HDLC_MAX_KHZ,
   output logic [cprsc_pkg::HFN_W-1:0] O_TX_HFN,
   output logic [cprsc_pkg::BFN_W-1:0] O_TX_BFN,
   output logic O_TIMER_TICK,
   output logic O_TEST_MODE,
   output logic O_ROLE_REC
);
   import cprsc_pkg::*;

   // Refuse shapes the decode and timer cannot serve
   if (RATE_W < 2 || RATE_W > RATE_FW || TIMER_CYCLES < TEST_DIV) begin : g_bad_cfg
      $error("cprsc_static_ctrl: unsupported RATE_W or TIMER_CYCLES");
   end

   // Word index of a byte address
   function automatic logic [5:0] word_idx(input logic [AXI_AW-1:0] a);
      word_idx = a[AXI_AW-1:2];
   endfunction : word_idx

   // Merge write data under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
      end
   endfunction : merge

   // Bus state
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic aw_fire, w_fire, ar_fire, wr_fire;
   logic [5:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   // Register state
   logic [31:0] ctrl_r, ctrl_nxt, ptr_r, ptr_nxt, hdlc_r, hdlc_nxt, init_r, init_nxt;
   logic load_r, load_nxt, stby_q_r, stby_q_nxt, stby_pulse_r, stby_pulse_nxt;

   // Derived outputs and timer
   logic [15:0] line_x_r, line_x_nxt, srd_x_r, srd_x_nxt;
   logic [11:0] hdlc_khz_r, hdlc_khz_nxt;
   logic [31:0] tmr_cnt_r, tmr_cnt_nxt, tmr_limit;
   logic tick_r, tick_nxt;

   cprsc_cnt_if cnt_bus ();

   // Handshakes; ready drops while frozen so nothing is taken unseen
   assign O_AXI_AWREADY = I_CE & ~aw_full_r & ~bvalid_r;
   assign O_AXI_WREADY = I_CE & ~w_full_r & ~bvalid_r;
   assign O_AXI_ARREADY = I_CE & ~rvalid_r;
   assign aw_fire = I_AXI_AWVALID & O_AXI_AWREADY;
   assign w_fire = I_AXI_WVALID & O_AXI_WREADY;
   assign ar_fire = I_AXI_ARVALID & O_AXI_ARREADY;
   assign wr_fire = (aw_full_r | aw_fire) & (w_full_r | w_fire) & ~bvalid_r;
   assign wr_idx = word_idx(aw_full_r ? awaddr_r : I_AXI_AWADDR);
   assign wr_data = w_full_r ? wdata_r : I_AXI_WDATA;
   assign wr_strb = w_full_r ? wstrb_r : I_AXI_WSTRB;

   // Bus next state; address and data are held until both are present
   always_comb begin
      aw_full_nxt = (aw_full_r | aw_fire) & ~wr_fire;
      w_full_nxt = (w_full_r | w_fire) & ~wr_fire;
      awaddr_nxt = aw_fire ? I_AXI_AWADDR : awaddr_r;
      wdata_nxt = w_fire ? I_AXI_WDATA : wdata_r;
      wstrb_nxt = w_fire ? I_AXI_WSTRB : wstrb_r;
      bvalid_nxt = wr_fire | (bvalid_r & ~I_AXI_BREADY);
      bresp_nxt = bresp_r;
      if (wr_fire) begin
         bresp_nxt = (wr_idx <= IDX_RATE) ? RESP_OKAY : RESP_SLVERR;
      end
      rvalid_nxt = ar_fire | (rvalid_r & ~I_AXI_RREADY);
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (ar_fire) begin
         rresp_nxt = RESP_OKAY;
         unique case (word_idx(I_AXI_ARADDR))
            IDX_CTRL: rdata_nxt = ctrl_r;
            IDX_PTR: rdata_nxt = ptr_r;
            IDX_HDLC: rdata_nxt = hdlc_r;
            IDX_INIT: rdata_nxt = init_r;
            IDX_COUNT: rdata_nxt = {4'h0, O_TX_BFN, 8'h00, O_TX_HFN};
            IDX_RATE: rdata_nxt = {srd_x_r, line_x_r};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (I_CE) begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Configuration registers; an init write also reloads the counters
   always_comb begin
      ctrl_nxt = ctrl_r;
      ptr_nxt = ptr_r;
      hdlc_nxt = hdlc_r;
      init_nxt = init_r;
      load_nxt = 1'b0;
      if (wr_fire) begin
         unique case (wr_idx)
            IDX_CTRL: ctrl_nxt = merge(ctrl_r, wr_data, wr_strb) & CTRL_WMASK;
            IDX_PTR: ptr_nxt = merge(ptr_r, wr_data, wr_strb) & 32'h0000_00ff;
            IDX_HDLC: hdlc_nxt = merge(hdlc_r, wr_data, wr_strb) & 32'h0000_001f;
            IDX_INIT: begin
               init_nxt = merge(init_r, wr_data, wr_strb) & 32'h0fff_00ff;
               load_nxt = 1'b1;
            end
            default: ;
         endcase
      end
      stby_q_nxt = ctrl_r[CTRL_STBY];
      stby_pulse_nxt = ctrl_r[CTRL_STBY] & ~stby_q_r;
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         ctrl_r <= CTRL_RST;
         ptr_r <= 32'h0000_0000;
         hdlc_r <= 32'h0000_0000;
         init_r <= 32'h0000_0000;
         load_r <= 1'b0;
         stby_q_r <= 1'b0;
         stby_pulse_r <= 1'b0;
      end else if (I_CE) begin
         ctrl_r <= ctrl_nxt;
         ptr_r <= ptr_nxt;
         hdlc_r <= hdlc_nxt;
         init_r <= init_nxt;
         load_r <= load_nxt;
         stby_q_r <= stby_q_nxt;
         stby_pulse_r <= stby_pulse_nxt;
      end
   end

   // Rate decode, highest enabled HDLC rate, and the internal timer
   always_comb begin
      line_x_nxt = rate_x100k(RATE_FW'(ctrl_r[CTRL_LBR_LSB +: RATE_W]), VARIANT_3G, 1'b1);
      srd_x_nxt = rate_x100k(RATE_FW'(ctrl_r[CTRL_SRD_LSB +: RATE_W]), VARIANT_3G, 1'b0);
      hdlc_khz_nxt = 12'h000;
      for (int i = 0; i < HDLC_N; i++) begin
         if (hdlc_r[i]) begin
            hdlc_khz_nxt = HDLC_KHZ[i];
         end
      end
      // Test mode shortens the period so a bench sees ticks quickly
      tmr_limit = ctrl_r[CTRL_TEST] ? 32'(TIMER_CYCLES / TEST_DIV) : 32'(TIMER_CYCLES);
      tick_nxt = (tmr_cnt_r >= tmr_limit - 32'h1);
      tmr_cnt_nxt = tick_nxt ? 32'h0 : tmr_cnt_r + 32'h1;
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RST_N) begin
         line_x_r <= RATE_614;
         srd_x_r <= RATE_614;
         hdlc_khz_r <= 12'h000;
         tmr_cnt_r <= 32'h0;
         tick_r <= 1'b0;
      end else if (I_CE) begin
         line_x_r <= line_x_nxt;
         srd_x_r <= srd_x_nxt;
         hdlc_khz_r <= hdlc_khz_nxt;
         tmr_cnt_r <= tmr_cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // Counter controls
   assign cnt_bus.auto_cnt = ctrl_r[CTRL_AUTO];
   assign cnt_bus.hyp_rst_en = ctrl_r[CTRL_HRST];
   assign cnt_bus.bfn_rst_en = ctrl_r[CTRL_BRST];
   assign cnt_bus.load = load_r;
   assign cnt_bus.sync = I_TX_SYNC;
   assign cnt_bus.hyper_tick = I_HYPER_TICK;
   assign cnt_bus.init_hfn = init_r[FN_HFN_LSB +: HFN_W];
   assign cnt_bus.init_bfn = init_r[FN_BFN_LSB +: BFN_W];

   cprsc_frame_cnt u_cnt (
      .i_clock(I_CLOCK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .cnt(cnt_bus)
   );

   // Outputs
   assign O_AXI_BVALID = bvalid_r;
   assign O_AXI_BRESP = bresp_r;
   assign O_AXI_RVALID = rvalid_r;
   assign O_AXI_RDATA = rdata_r;
   assign O_AXI_RRESP = rresp_r;
   assign O_LINE_RATE_SEL = ctrl_r[CTRL_LBR_LSB +: RATE_W];
   assign O_SERDES_RATE_SEL = ctrl_r[CTRL_SRD_LSB +: RATE_W];
   assign O_LINE_RATE_X100K = line_x_r;
   assign O_SERDES_RATE_X100K = srd_x_r;
   assign O_STANDBY_FORCE = stby_pulse_r;
   assign O_TX_POINTER = ptr_r[PTR_W-1:0];
   assign O_HDLC_EN = hdlc_r[HDLC_N-1:0];
   assign O_HDLC_MAX_KHZ = hdlc_khz_r;
   assign O_TX_HFN = cnt_bus.hfn;
   assign O_TX_BFN = cnt_bus.bfn;
   assign O_TIMER_TICK = tick_r;
   assign O_TEST_MODE = ctrl_r[CTRL_TEST];
   assign O_ROLE_REC = ctrl_r[CTRL_ROLE];

   // Checks
   a_rate_line: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_LBR_LSB +: 2] == 2'd2) |=> O_LINE_RATE_X100K == RATE_2457)
      else $error("line rate code 2 not decoded");
   a_rate_serdes: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_SRD_LSB +: 3] == 3'd3) |=> O_SERDES_RATE_X100K == RATE_3072)
      else $error("serdes rate code 3 not decoded");
   a_standby_edge: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_STBY] && !stby_q_r) |=> O_STANDBY_FORCE)
      else $error("standby edge gave no pulse");
   a_standby_level: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && stby_q_r) |=> !O_STANDBY_FORCE)
      else $error("standby level gave a pulse");
   a_pointer_write: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && wr_fire && wr_idx == IDX_PTR && wr_strb[0]) |=> O_TX_POINTER == $past(wr_data[7:0]))
      else $error("pointer write not applied");
   a_hdlc_top: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && hdlc_r[4]) |=> O_HDLC_MAX_KHZ == 12'h960)
      else $error("2400 kHz enable not honoured");
   a_hfn_fixed: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && !ctrl_r[CTRL_AUTO]) |=> O_TX_HFN == $past(init_r[7:0]))
      else $error("hfn not taken from init value");
   a_bfn_load: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && load_r) |=> O_TX_BFN == $past(init_r[27:16]))
      else $error("bfn not loaded from init value");
   a_hfn_sync: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_AUTO] && ctrl_r[CTRL_HRST] && I_TX_SYNC && !load_r)
      |=> O_TX_HFN == 8'h00)
      else $error("sync did not clear hfn");
   a_hfn_keep: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_AUTO] && !ctrl_r[CTRL_HRST] && I_TX_SYNC && !I_HYPER_TICK
       && !load_r) |=> $stable(O_TX_HFN))
      else $error("sync changed hfn while disabled");
   a_bfn_sync: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_AUTO] && ctrl_r[CTRL_BRST] && I_TX_SYNC && !load_r)
      |=> O_TX_BFN == 12'h000)
      else $error("sync did not clear bfn");
   a_timer_bound: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_CE && ctrl_r[CTRL_TEST] && $stable(ctrl_r[CTRL_TEST]))
      |-> tmr_cnt_r < 32'(TIMER_CYCLES / TEST_DIV))
      else $error("test timer overran its short period");
endmodule : cprsc_static_ctrl
`default_nettype wire

// >>> cprsc_pkg.sv
// Shared constants, register map and decode helpers for the static control block
`default_nettype none
package cprsc_pkg;
   // Clock and internal timer
   localparam int CLK_NS = 20;
   localparam int TIMER_NS = 1000000;
   localparam int TIMER_CYC = TIMER_NS / CLK_NS;
   localparam int TEST_DIV = 64;
   // Bus geometry
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Register word indices (byte address is four times these)
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_PTR = 6'h01;
   localparam logic [5:0] IDX_HDLC = 6'h02;
   localparam logic [5:0] IDX_INIT = 6'h03;
   localparam logic [5:0] IDX_COUNT = 6'h04;
   localparam logic [5:0] IDX_RATE = 6'h05;
   // Control register fields
   localparam int CTRL_LBR_LSB = 0;
   localparam int CTRL_SRD_LSB = 4;
   localparam int CTRL_STBY = 8;
   localparam int CTRL_AUTO = 9;
   localparam int CTRL_HRST = 10;
   localparam int CTRL_BRST = 11;
   localparam int CTRL_TEST = 12;
   localparam int CTRL_ROLE = 13;
   localparam int RATE_FW = 3;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_3f77;
   localparam logic [31:0] CTRL_RST = 32'h0000_0200;
   // Init and count register fields
   localparam int HFN_W = 8;
   localparam int BFN_W = 12;
   localparam int FN_HFN_LSB = 0;
   localparam int FN_BFN_LSB = 16;
   localparam logic [HFN_W-1:0] HFN_LAST = 8'hff;
   localparam logic [HFN_W-1:0] HFN_RST = 8'h00;
   localparam logic [BFN_W-1:0] BFN_RST = 12'h000;
   // Pointer and HDLC
   localparam int PTR_W = 8;
   localparam logic [PTR_W-1:0] PTR_MAX = 8'h3f;
   localparam int HDLC_N = 5;
   localparam logic [11:0] HDLC_KHZ [HDLC_N] = '{12'h0f0, 12'h1e0, 12'h3c0, 12'h780, 12'h960};
   // Rates in units of 100 kbps
   localparam logic [15:0] RATE_614 = 16'h1800;
   localparam logic [15:0] RATE_1228 = 16'h3000;
   localparam logic [15:0] RATE_2457 = 16'h6000;
   localparam logic [15:0] RATE_3072 = 16'h7800;
   localparam logic [15:0] RATE_NONE = 16'h0000;

   // Turns a rate code into a rate; line select code 3 depends on the variant
   function automatic logic [15:0] rate_x100k(input logic [RATE_FW-1:0] code,
                                              input logic three_g, input logic is_line);
      case (code)
         3'h0: rate_x100k = RATE_614;
         3'h1: rate_x100k = RATE_1228;
         3'h2: rate_x100k = RATE_2457;
         3'h3: rate_x100k = (three_g || !is_line) ? RATE_3072 : RATE_2457;
         default: rate_x100k = RATE_NONE;
      endcase
   endfunction : rate_x100k
endpackage : cprsc_pkg
`default_nettype wire

// >>> cprsc_cnt_if.sv
// Carrier between the register side and the frame number counters
`timescale 1ns/1ns
`default_nettype none
interface cprsc_cnt_if;
   import cprsc_pkg::*;
   logic auto_cnt;
   logic hyp_rst_en;
   logic bfn_rst_en;
   logic load;
   logic sync;
   logic hyper_tick;
   logic [HFN_W-1:0] init_hfn;
   logic [BFN_W-1:0] init_bfn;
   logic [HFN_W-1:0] hfn;
   logic [BFN_W-1:0] bfn;
   modport ctrl (output auto_cnt, hyp_rst_en, bfn_rst_en, load, sync, hyper_tick,
                 output init_hfn, init_bfn, input hfn, bfn);
   modport counter (input auto_cnt, hyp_rst_en, bfn_rst_en, load, sync, hyper_tick,
                    input init_hfn, init_bfn, output hfn, bfn);
endinterface : cprsc_cnt_if
`default_nettype wire

// >>> cprsc_frame_cnt.sv
// Transmit hyperframe and node-B frame number counters
`timescale 1ns/1ns
`default_nettype none
module cprsc_frame_cnt (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Controls in, counts out
   cprsc_cnt_if.counter cnt
);
   import cprsc_pkg::*;

   logic [HFN_W-1:0] hfn_r;
   logic [HFN_W-1:0] hfn_nxt;
   logic [BFN_W-1:0] bfn_r;
   logic [BFN_W-1:0] bfn_nxt;

   // Next counts; a load beats a sync so a fresh start value is never lost
   always_comb begin
      hfn_nxt = hfn_r;
      bfn_nxt = bfn_r;
      if (!cnt.auto_cnt || cnt.load) begin
         hfn_nxt = cnt.init_hfn;
         bfn_nxt = cnt.init_bfn;
      end else begin
         if (cnt.hyper_tick) begin
            hfn_nxt = (hfn_r == HFN_LAST) ? HFN_RST : hfn_r + 8'h01;
            if (hfn_r == HFN_LAST) begin
               bfn_nxt = bfn_r + 12'h001;
            end
         end
         if (cnt.sync && cnt.hyp_rst_en) begin
            hfn_nxt = HFN_RST;
         end
         if (cnt.sync && cnt.bfn_rst_en) begin
            bfn_nxt = BFN_RST;
         end
      end
   end

   // Count registers
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         hfn_r <= HFN_RST;
         bfn_r <= BFN_RST;
      end else if (i_ce) begin
         hfn_r <= hfn_nxt;
         bfn_r <= bfn_nxt;
      end
   end

   assign cnt.hfn = hfn_r;
   assign cnt.bfn = bfn_r;
endmodule : cprsc_frame_cnt
`default_nettype wire

// >>> cprsc_evt_src.sv
// Framing event source standing in for the user logic beside the core
`timescale 1ns/1ns
`default_nettype none
module cprsc_evt_src (
   // Clock and requests from the bench
   input wire logic i_clock,
   input wire logic i_req_sync,
   input wire logic i_req_tick,
   // One-cycle framing pulses
   output var logic o_sync = 1'b0,
   output var logic o_tick = 1'b0
);
   // Registered so the pulses always leave just after an edge of the core clock
   always_ff @(posedge i_clock) begin
      o_sync <= i_req_sync;
      o_tick <= i_req_tick;
   end
endmodule : cprsc_evt_src
`default_nettype wire

// >>> cpri_static_control_inputs_test.sv
// Self-checking bench for the static configuration block
`timescale 1ns/1ns
`default_nettype none
module cpri_static_control_inputs_test;
   import cprsc_pkg::*;
   // Short timer so both timer modes fit in a brief run
   localparam int TCYC = 128;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic req_sync = 1'b0, req_tick = 1'b0;
   wire logic sync, tick, awready, wready, bvalid, arready, rvalid, stby, ttick, tmode, role;
   wire logic [1:0] bresp, rresp, lsel, ssel;
   wire logic [31:0] rdata;
   wire logic [15:0] lrate, srate;
   wire logic [7:0] ptr, hfn;
   wire logic [4:0] hen;
   wire logic [11:0] hkhz, bfn;
   int mismatches = 0, samples_checked = 0, stby_cnt = 0, tick_cnt = 0;
   int seed = 32'h4ca656ed;
   logic [1:0] resp;
   logic [31:0] rd, v;

   cprsc_static_ctrl #(.RATE_W(2), .VARIANT_3G(1'b1), .TIMER_CYCLES(TCYC)) dut (
      .I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(ce),
      .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
      .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
      .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
      .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
      .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
      .I_TX_SYNC(sync), .I_HYPER_TICK(tick), .O_LINE_RATE_SEL(lsel), .O_SERDES_RATE_SEL(ssel),
      .O_LINE_RATE_X100K(lrate), .O_SERDES_RATE_X100K(srate), .O_STANDBY_FORCE(stby),
      .O_TX_POINTER(ptr), .O_HDLC_EN(hen), .O_HDLC_MAX_KHZ(hkhz), .O_TX_HFN(hfn),
      .O_TX_BFN(bfn), .O_TIMER_TICK(ttick), .O_TEST_MODE(tmode), .O_ROLE_REC(role));

   cprsc_evt_src partner (.i_clock(clk), .i_req_sync(req_sync), .i_req_tick(req_tick),
      .o_sync(sync), .o_tick(tick));

   // 50 MHz core clock
   always #10 clk = ~clk;

   // Pulses are counted mid-cycle, where the outputs are settled
   always @(negedge clk) begin
      if (stby === 1'b1)
         stby_cnt++;
      if (ttick === 1'b1)
         tick_cnt++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Address and data offered together; each released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_hit, w_hit;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge clk);
         if (!awvalid && !wvalid)
            break;
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         @(posedge clk);
         if (aw_hit)
            awvalid <= 1'b0;
         if (w_hit)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1) @(negedge clk);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge clk);
      while (arready !== 1'b1) @(negedge clk);
      @(posedge clk);
      arvalid <= 1'b0;
      @(negedge clk);
      while (rvalid !== 1'b1) @(negedge clk);
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : rd_reg

   // Lets register and derived outputs land before they are compared
   task automatic settle;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic pulse(input bit s);
      @(posedge clk);
      if (s)
         req_sync <= 1'b1;
      else
         req_tick <= 1'b1;
      @(posedge clk);
      req_sync <= 1'b0;
      req_tick <= 1'b0;
      settle;
   endtask : pulse

   function automatic logic [15:0] rate_exp(input int c);
      case (c)
         0: return RATE_614;
         1: return RATE_1228;
         2: return RATE_2457;
         default: return RATE_3072;
      endcase
   endfunction : rate_exp

   function automatic logic [11:0] khz_exp(input logic [31:0] e);
      khz_exp = 12'h000;
      for (int i = 0; i < HDLC_N; i++)
         if (e[i])
            khz_exp = HDLC_KHZ[i];
   endfunction : khz_exp

   task automatic finish_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Whole sequence needs under two thousand cycles; this is a generous ceiling
   initial begin
      repeat (50000) @(posedge clk);
      mismatches++;
      finish_test;
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      rd_reg(8'h00);
      check(rd, CTRL_RST);
      check(lrate, RATE_614);
      // Every line and serdes code, role toggled alongside
      for (int i = 0; i < 16; i++) begin
         v = CTRL_RST | 32'(i % 4) | (32'(i / 4) << 4) | (32'(i % 3 == 0) << 13);
         wr(8'h00, v);
         settle;
         check(lsel, i % 4);
         check(lrate, rate_exp(i % 4));
         check(ssel, i / 4);
         check(srate, rate_exp(i / 4));
         check(role, i % 3 == 0);
         rd_reg(8'h00);
         check(rd, v);
      end
      // Standby force acts on the rising edge only
      stby_cnt = 0;
      wr(8'h00, CTRL_RST | 32'h100);
      wr(8'h00, CTRL_RST | 32'h100);
      settle;
      check(stby_cnt, 1);
      wr(8'h00, CTRL_RST);
      wr(8'h00, CTRL_RST | 32'h100);
      settle;
      check(stby_cnt, 2);
      // Pointer, top of the legal range first
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'h3f : 32'($random(seed)) & 32'h3f;
         wr(8'h04, v);
         settle;
         check(ptr, v);
      end
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 32'h0 : 32'($random(seed)) & 32'h1f;
         wr(8'h08, v);
         settle;
         check(hen, v);
         check(hkhz, khz_exp(v));
      end
      // Counter load and advance
      v = (32'($random(seed)) & 32'h0fff_007f);
      wr(8'h0c, v);
      settle;
      check(hfn, v[7:0]);
      check(bfn, v[27:16]);
      pulse(1'b0);
      check(hfn, v[7:0] + 8'h01);
      rd_reg(8'h10);
      check(rd, {4'h0, v[27:16], 8'h00, v[7:0] + 8'h01});
      wr(8'h0c, 32'h0fff_00ff);
      pulse(1'b0);
      check({bfn, hfn}, 20'h0);
      // Sync clears only the numbers whose enable is set
      wr(8'h0c, 32'h0007_0005);
      wr(8'h00, CTRL_RST | 32'h400);
      pulse(1'b1);
      check({bfn, hfn}, 20'h007_00);
      wr(8'h00, CTRL_RST | 32'h800);
      pulse(1'b0);
      pulse(1'b1);
      check({bfn, hfn}, 20'h000_01);
      wr(8'h00, CTRL_RST);
      pulse(1'b0);
      pulse(1'b1);
      check({bfn, hfn}, 20'h000_02);
      // Without automatic count the numbers follow the init value
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'h0123_0045);
      pulse(1'b0);
      check({bfn, hfn}, 20'h123_45);
      // Timer period in normal and test mode
      for (int m = 0; m < 2; m++) begin
         wr(8'h00, CTRL_RST | (32'(m) << 12));
         repeat (2 * TCYC) @(posedge clk);
         tick_cnt = 0;
         repeat (2 * TCYC) @(posedge clk);
         check(tick_cnt, m ? 2 * TEST_DIV : 2);
         check(tmode, m);
      end
      // Clock enable low freezes the counters even through a hyperframe tick
      ce <= 1'b0;
      pulse(1'b0);
      check(hfn, 8'h45);
      ce <= 1'b1;
      pulse(1'b0);
      check(hfn, 8'h46);
      // Unmapped and read-only places
      wr(8'h40, 32'hffff_ffff);
      check(resp, RESP_SLVERR);
      rd_reg(8'h40);
      check(32'(resp), 32'(RESP_SLVERR));
      check(rd, 32'h0);
      wr(8'h14, 32'hffff_ffff);
      check(resp, RESP_OKAY);
      finish_test;
   end
endmodule : cpri_static_control_inputs_test
`default_nettype wire
